// File: verilog/instr_decode_regs.svh
`ifndef INSTR_DECODE_REGS_SVH
`define INSTR_DECODE_REGS_SVH
// Function
// - Keep a 21-bit table pointer addressing program memory for table access.
// - Byte ops take low byte as file address; d=0 accumulator, d=1 file.
// - Access bit zero selects access bank; one uses bank select upper bits.
// - File-to-file move is two words, 12-bit source then 1111-prefixed dest.
// - Bit ops decode a 3-bit bit number plus access bit and file address.
// - Literal ops take an 8-bit immediate from the low byte.
// - Jump and call build 20-bit target from two words, second 1111-prefixed.
// - Unconditional relative jump decodes an 11-bit offset from bits 10:0.
// - Conditional branches decode an 8-bit offset from bits 7:0.
// - Add ops 0010 01da and 00da, one cycle, update all five flags.
// - Logical ops OR, AND, complement, one cycle, update zero and negative.
// - Compare-skip ops under 0110, one or three cycles, no flag change.
// - Increment and decrement skip-if-zero store result, skip, keep flags.
// - File-to-file move executes in two instruction cycles, no flag change.
// - A lone 1111-prefixed second word executes as a no-operation.
// - One instruction cycle spans four oscillator periods.
// - Fast bit on call or return saves or restores via shadow registers.

// ----------------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------------
`define DEC_TABLE_POINTER_W 21
`define DEC_DEST_BIT 9
`define DEC_ACC_BIT 8
`define DEC_FAST_BIT 8
`define DEC_SECOND_PFX 4'hf
`define DEC_PHASES 2'h3
`define FLAG_C 5'h01
`define FLAG_DIGIT_CARRY 5'h02
`define FLAG_Z 5'h04
`define FLAG_OVERFLOW 5'h08
`define FLAG_N 5'h10
`define FLAG_ALL 5'h1f
`define FLAG_NONE 5'h00
`endif

// File: verilog/instr_decode_pkg.sv
package instr_decode_pkg;
   // Decoded operation classes.
   typedef enum logic [4:0]
   {
      op_nop = 5'h00,
      op_add = 5'h01,
      op_add_with_carry = 5'h02,
      op_or = 5'h03,
      op_and = 5'h04,
      op_complement = 5'h05,
      op_cmp_skip_equal = 5'h06,
      op_cmp_skip_greater = 5'h07,
      op_cmp_skip_less = 5'h08,
      op_inc_skip_zero = 5'h09,
      op_dec_skip_zero = 5'h0a,
      op_file_to_file_move = 5'h0b,
      op_relative_jump = 5'h0c,
      op_branch_cond = 5'h0d,
      op_goto = 5'h0e,
      op_call = 5'h0f,
      op_return = 5'h10,
      op_bit = 5'h11,
      op_literal = 5'h12,
      op_unknown = 5'h13
   } op_type;

   typedef enum logic [1:0]
   {
      st_first = 2'b00,
      st_second = 2'b01
   } seq_type;
endpackage

// File: verilog/phase_counter.sv
`timescale 1ns/1ps
`include "instr_decode_regs.svh"
// ----------------------------------------------------------------------
// Four-phase instruction cycle timer
// ----------------------------------------------------------------------
module phase_counter
(
   input wire logic clk_sys,
   input wire logic resetn,
   output logic [1:0] phase,
   output logic cycle_end
);
   // Each oscillator period is one clk_sys edge; four make a cycle.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end

   // The last phase marks the edge on which the decoder takes a word.
   assign cycle_end = (phase == `DEC_PHASES);

   a_phase_wrap: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      cycle_end |=> (phase == 2'h0))
      else $error("Phase did not wrap after cycle end.");
endmodule

// File: verilog/instruction_word_decoder.sv
`timescale 1ns/1ps
`include "instr_decode_regs.svh"
// ----------------------------------------------------------------------
// Instruction word decoder
// ----------------------------------------------------------------------
module instruction_word_decoder
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_reg,
   input wire logic skip_taken,
   input wire logic table_pointer_load,
   input wire logic [20:0] table_pointer_value,
   input wire logic table_pointer_inc,
   output logic [4:0] op_code_out_reg,
   output logic dest_file_reg,
   output logic [11:0] file_addr_reg,
   output logic [11:0] dest_addr_reg,
   output logic [2:0] bit_pos_reg,
   output logic [7:0] literal_reg,
   output logic [19:0] target_reg,
   output logic [10:0] rel_offset_reg,
   output logic [4:0] flag_mask_reg,
   output logic [1:0] cycles_reg,
   output logic shadow_save_reg,
   output logic shadow_restore_reg,
   output logic decode_valid_reg,
   output logic [20:0] table_pointer_reg
);
   logic [1:0] phase;
   logic cycle_end;
   instr_decode_pkg::seq_type seq_reg;
   instr_decode_pkg::op_type op_next;
   instr_decode_pkg::op_type pend_reg;
   logic [11:0] fa_next;
   logic [4:0] mask_next;
   logic [1:0] cyc_next;
   logic [7:0] low_byte_reg;
   logic is_second;

   phase_counter u_phase
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   // Second words carry four ones on top; alone they execute as a no-op.
   assign is_second = (instr_word[15:12] == `DEC_SECOND_PFX);

   // Classify the word; only the fixed opcode bits are compared, so don't-care
   // bits fall through untouched.
   always_comb
   begin
      op_next = instr_decode_pkg::op_unknown;
      mask_next = `FLAG_NONE;
      cyc_next = 2'h1;
      case (instr_word[15:12])
         4'h0:
            if (instr_word[11:0] == 12'h000)
               op_next = instr_decode_pkg::op_nop;
            else if (instr_word[11:1] == 11'h009)
               op_next = instr_decode_pkg::op_return;
         4'h1:
         begin
            mask_next = `FLAG_Z | `FLAG_N;
            case (instr_word[11:10])
               2'h0: op_next = instr_decode_pkg::op_or;
               2'h1: op_next = instr_decode_pkg::op_and;
               2'h3: op_next = instr_decode_pkg::op_complement;
               default:
               begin
                  op_next = instr_decode_pkg::op_unknown;
                  mask_next = `FLAG_NONE;
               end
            endcase
         end
         4'h2:
            case (instr_word[11:10])
               2'h1:
               begin
                  op_next = instr_decode_pkg::op_add;
                  mask_next = `FLAG_ALL;
               end
               2'h0:
               begin
                  op_next = instr_decode_pkg::op_add_with_carry;
                  mask_next = `FLAG_ALL;
               end
               2'h3: op_next = instr_decode_pkg::op_dec_skip_zero;
               default: op_next = instr_decode_pkg::op_unknown;
            endcase
         4'h3:
            if (instr_word[11:10] == 2'h3)
               op_next = instr_decode_pkg::op_inc_skip_zero;
         4'h6:
            case (instr_word[11:9])
               3'h1: op_next = instr_decode_pkg::op_cmp_skip_equal;
               3'h2: op_next = instr_decode_pkg::op_cmp_skip_greater;
               3'h0: op_next = instr_decode_pkg::op_cmp_skip_less;
               default: op_next = instr_decode_pkg::op_unknown;
            endcase
         4'h7, 4'h8, 4'h9, 4'ha, 4'hb:
            op_next = instr_decode_pkg::op_bit;
         4'hc:
         begin
            op_next = instr_decode_pkg::op_file_to_file_move;
            cyc_next = 2'h2;
         end
         4'hd:
            if (!instr_word[11])
               op_next = instr_decode_pkg::op_relative_jump;
         4'he:
            if (instr_word[11] == 1'b0)
               op_next = instr_decode_pkg::op_branch_cond;
            else if (instr_word[11:9] == 3'h6)
            begin
               op_next = instr_decode_pkg::op_call;
               cyc_next = 2'h2;
            end
            else if (instr_word[11:8] == 4'hf)
            begin
               op_next = instr_decode_pkg::op_goto;
               cyc_next = 2'h2;
            end
         4'hf:
            op_next = instr_decode_pkg::op_nop;
         default:
            op_next = instr_decode_pkg::op_unknown;
      endcase
      // Skip-capable ops stretch to three cycles when the skip hits.
      if (skip_taken && (op_next == instr_decode_pkg::op_cmp_skip_equal
         || op_next == instr_decode_pkg::op_cmp_skip_greater
         || op_next == instr_decode_pkg::op_cmp_skip_less
         || op_next == instr_decode_pkg::op_inc_skip_zero
         || op_next == instr_decode_pkg::op_dec_skip_zero))
         cyc_next = 2'h3;
   end

   // Banked address: access bit clear forces the access bank.
   always_comb
   begin
      if (instr_word[`DEC_ACC_BIT])
         fa_next = {bank_select_reg, instr_word[7:0]};
      else
         fa_next = {4'h0, instr_word[7:0]};
   end

   // Word sequencing, advanced once per instruction cycle.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         seq_reg <= instr_decode_pkg::st_first;
         pend_reg <= instr_decode_pkg::op_nop;
         low_byte_reg <= 8'h00;
      end
      else if (cycle_end)
      begin
         case (seq_reg)
            instr_decode_pkg::st_first:
               if (cyc_next == 2'h2)
               begin
                  seq_reg <= instr_decode_pkg::st_second;
                  pend_reg <= op_next;
                  low_byte_reg <= instr_word[7:0];
               end
            instr_decode_pkg::st_second:
               seq_reg <= instr_decode_pkg::st_first;
            default:
               seq_reg <= instr_decode_pkg::st_first;
         endcase
      end
   end

   // Decoded outputs, registered at the end of each instruction cycle.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         op_code_out_reg <= 5'h00;
         dest_file_reg <= 1'b0;
         file_addr_reg <= 12'h000;
         dest_addr_reg <= 12'h000;
         bit_pos_reg <= 3'h0;
         literal_reg <= 8'h00;
         target_reg <= 20'h00000;
         rel_offset_reg <= 11'h000;
         flag_mask_reg <= 5'h00;
         cycles_reg <= 2'h0;
         shadow_save_reg <= 1'b0;
         shadow_restore_reg <= 1'b0;
         decode_valid_reg <= 1'b0;
      end
      else if (cycle_end)
      begin
         decode_valid_reg <= 1'b1;
         if (seq_reg == instr_decode_pkg::st_second)
         begin
            // Second word: only its payload is used; a bad prefix gives nop.
            op_code_out_reg <= is_second ? pend_reg
               : instr_decode_pkg::op_nop;
            flag_mask_reg <= `FLAG_NONE;
            cycles_reg <= 2'h2;
            if (pend_reg == instr_decode_pkg::op_file_to_file_move)
               dest_addr_reg <= instr_word[11:0];
            else
               target_reg <= {instr_word[11:0], low_byte_reg};
         end
         else
         begin
            op_code_out_reg <= op_next;
            flag_mask_reg <= mask_next;
            cycles_reg <= cyc_next;
            dest_file_reg <= instr_word[`DEC_DEST_BIT];
            file_addr_reg <= (op_next
               == instr_decode_pkg::op_file_to_file_move)
               ? instr_word[11:0] : fa_next;
            bit_pos_reg <= instr_word[11:9];
            literal_reg <= instr_word[7:0];
            rel_offset_reg <= (op_next == instr_decode_pkg::op_relative_jump)
               ? instr_word[10:0] : {3'h0, instr_word[7:0]};
            shadow_save_reg <= (op_next == instr_decode_pkg::op_call)
               && instr_word[`DEC_FAST_BIT];
            shadow_restore_reg <= (op_next == instr_decode_pkg::op_return)
               && instr_word[0];
         end
      end
   end

   // Table pointer for program memory table access.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         table_pointer_reg <= 21'h000000;
      else if (table_pointer_load)
         table_pointer_reg <= table_pointer_value;
      else if (table_pointer_inc)
         table_pointer_reg <= table_pointer_reg + 21'h000001;
   end

   // Decode checks look one clock after the decode edge, once it settled.
   a_add_flags: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:10] == 6'h09)
      |=> (flag_mask_reg == `FLAG_ALL && cycles_reg == 2'h1))
      else $error("Add did not set full flag mask.");
   a_logic_flags: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:12] == 4'h1 && instr_word[11:10] != 2'h2)
      |=> (flag_mask_reg == 5'h14))
      else $error("Logical op flag mask wrong.");
   a_move_two: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:12] == 4'hc)
      |=> (file_addr_reg == $past(instr_word[11:0])
      && seq_reg == instr_decode_pkg::st_second))
      else $error("Move first word not captured.");
   a_lone_nop: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first && is_second)
      |=> (op_code_out_reg == 5'h00))
      else $error("Lone second word not a no-op.");
   a_bank_sel: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:12] == 4'h2 && !instr_word[8])
      |=> (file_addr_reg[11:8] == 4'h0))
      else $error("Access bank not forced.");
   a_skip_cycles: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:9] == 7'h31 && skip_taken)
      |=> (cycles_reg == 2'h3 && flag_mask_reg == 5'h00))
      else $error("Skip compare cycles wrong.");
   a_rel_jump: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (cycle_end && seq_reg == instr_decode_pkg::st_first
      && instr_word[15:11] == 5'h1a)
      |=> (rel_offset_reg == $past(instr_word[10:0])))
      else $error("Relative offset wrong.");
   a_tbl_load: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      table_pointer_load
      |=> (table_pointer_reg == $past(table_pointer_value)))
      else $error("Table pointer load lost.");
endmodule

// File: verification/program_memory_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Program memory model
// ----------------------------------------------------------------------
module program_memory_model
(
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [4:0] rd_addr,
   output logic [15:0] instr_word
);
   logic [15:0] mem [0:31];

   // Unwritten words read as erased flash, so a stray fetch gives a lone
   // second word rather than a value the simulator picks.
   initial
   begin
      for (int i = 0; i < 32; i++)
      begin
         mem[i] = 16'hffff;
      end
   end

   // The bench loads words one per edge; reads are asynchronous.
   always @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign instr_word = mem[rd_addr];
endmodule

// File: verification/test_instruction_word_decoder.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Decoder bench
// ----------------------------------------------------------------------
module test_instruction_word_decoder;
   typedef struct
   {
      logic [15:0] w;
      logic [3:0] bank;
      logic skip;
      logic [4:0] op;
      logic [4:0] mask;
      logic [1:0] cyc;
      logic [3:0] sel;
      logic [19:0] val;
   } row_type;
   row_type rows [0:26];
   row_type r;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] instr_word;
   logic [3:0] bank_select_reg = 4'h5;
   logic skip_taken = 1'b0;
   logic table_pointer_load = 1'b0;
   logic [20:0] table_pointer_value = 21'h000000;
   logic table_pointer_inc = 1'b0;
   logic wr_en = 1'b0;
   logic [4:0] wr_addr = 5'h00;
   logic [15:0] wr_data = 16'h0000;
   logic [4:0] rd_addr = 5'h00;
   logic [4:0] op_code_out_reg, flag_mask_reg;
   logic dest_file_reg, shadow_save_reg, shadow_restore_reg;
   logic [11:0] file_addr_reg, dest_addr_reg;
   logic [2:0] bit_pos_reg;
   logic [7:0] literal_reg;
   logic [19:0] target_reg;
   logic [10:0] rel_offset_reg;
   logic [1:0] cycles_reg;
   logic decode_valid_reg;
   logic [20:0] table_pointer_reg;
   int bad_count = 0;
   int check_count = 0;
   int n;

   // Clock at 100 ns period.
   always #50 clk_sys = ~clk_sys;

   program_memory_model i_program_memory_model (.clk_sys(clk_sys),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .instr_word(instr_word));

   instruction_word_decoder i_instruction_word_decoder (.clk_sys(clk_sys),
      .resetn(resetn), .instr_word(instr_word),
      .bank_select_reg(bank_select_reg), .skip_taken(skip_taken),
      .table_pointer_load(table_pointer_load),
      .table_pointer_value(table_pointer_value),
      .table_pointer_inc(table_pointer_inc),
      .op_code_out_reg(op_code_out_reg),
      .dest_file_reg(dest_file_reg), .file_addr_reg(file_addr_reg),
      .dest_addr_reg(dest_addr_reg), .bit_pos_reg(bit_pos_reg),
      .literal_reg(literal_reg), .target_reg(target_reg),
      .rel_offset_reg(rel_offset_reg), .flag_mask_reg(flag_mask_reg),
      .cycles_reg(cycles_reg), .shadow_save_reg(shadow_save_reg),
      .shadow_restore_reg(shadow_restore_reg),
      .decode_valid_reg(decode_valid_reg),
      .table_pointer_reg(table_pointer_reg));

   // Compares one value and counts it.
   task automatic check(input logic [20:0] seen, input logic [20:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Closing report.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Selects the field that a row checks besides op, mask and cycles.
   function automatic logic [20:0] pick(input logic [3:0] sel);
      case (sel)
         4'h0: pick = 21'({dest_file_reg, file_addr_reg});
         4'h1: pick = 21'(literal_reg);
         4'h2: pick = 21'(bit_pos_reg);
         4'h3: pick = 21'(rel_offset_reg);
         4'h4: pick = 21'(target_reg);
         4'h5: pick = 21'(dest_addr_reg);
         4'h6: pick = 21'(shadow_save_reg);
         4'h7: pick = 21'(shadow_restore_reg);
         default: pick = 21'(file_addr_reg);
      endcase
   endfunction

   // Word, bank, skip, op, flag mask, cycles (0 unchecked), field, value.
   initial
   begin
      rows = '{
      '{16'h2634,4'h5,1'h0,5'h01,5'h1f,2'h1,4'h0,20'h01034},
      '{16'h2135,4'ha,1'h0,5'h02,5'h1f,2'h1,4'h0,20'h00a35},
      '{16'h1034,4'h5,1'h0,5'h03,5'h14,2'h1,4'h0,20'h00034},
      '{16'h1734,4'h5,1'h0,5'h04,5'h14,2'h1,4'h0,20'h01534},
      '{16'h1e00,4'h5,1'h0,5'h05,5'h14,2'h1,4'h0,20'h01000},
      '{16'h24a5,4'h5,1'h0,5'h01,5'h1f,2'h1,4'h1,20'h000a5},
      '{16'h62ff,4'h5,1'h1,5'h06,5'h00,2'h3,4'h9,20'h000ff},
      '{16'h65ab,4'h5,1'h1,5'h07,5'h00,2'h3,4'h9,20'h005ab},
      '{16'h6012,4'h5,1'h0,5'h08,5'h00,2'h1,4'h9,20'h00012},
      '{16'h3e40,4'h5,1'h1,5'h09,5'h00,2'h3,4'h0,20'h01040},
      '{16'h2d40,4'h5,1'h0,5'h0a,5'h00,2'h1,4'h0,20'h00540},
      '{16'hc123,4'h5,1'h0,5'h0b,5'h00,2'h2,4'h9,20'h00123},
      '{16'hf456,4'h5,1'h0,5'h0b,5'h00,2'h2,4'h5,20'h00456},
      '{16'h9b12,4'h5,1'h0,5'h11,5'h00,2'h1,4'h2,20'h00005},
      '{16'hd7ff,4'h5,1'h0,5'h0c,5'h00,2'h0,4'h3,20'h007ff},
      '{16'he280,4'h5,1'h0,5'h0d,5'h00,2'h0,4'h3,20'h00080},
      '{16'hef12,4'h5,1'h0,5'h0e,5'h00,2'h2,4'h8,20'h00000},
      '{16'hfabc,4'h5,1'h0,5'h0e,5'h00,2'h2,4'h4,20'habc12},
      '{16'hed34,4'h5,1'h0,5'h0f,5'h00,2'h2,4'h6,20'h00001},
      '{16'hf001,4'h5,1'h0,5'h0f,5'h00,2'h2,4'h4,20'h00134},
      '{16'h0013,4'h5,1'h0,5'h10,5'h00,2'h0,4'h7,20'h00001},
      '{16'hf123,4'h5,1'h0,5'h00,5'h00,2'h0,4'h7,20'h00000},
      '{16'hfedc,4'h5,1'h0,5'h00,5'h00,2'h0,4'h6,20'h00000},
      '{16'hc000,4'h5,1'h0,5'h0b,5'h00,2'h2,4'h9,20'h00000},
      '{16'h2634,4'h5,1'h0,5'h00,5'h00,2'h0,4'h8,20'h00000},
      '{16'h2634,4'h5,1'h0,5'h01,5'h1f,2'h1,4'h0,20'h01034},
      '{16'h0004,4'h5,1'h0,5'h13,5'h00,2'h0,4'h8,20'h00000}};
      // Memory loads in the background; it stays ahead of the fetches.
      fork
         begin
            repeat (11) @(posedge clk_sys);
            @(negedge clk_sys);
            check(21'(decode_valid_reg), 21'h000000);
            @(posedge clk_sys);
            resetn <= 1'b1;
         end
         for (int i = 0; i < 27; i++)
         begin
            @(posedge clk_sys);
            wr_en <= 1'b1;
            wr_addr <= i[4:0];
            wr_data <= rows[i].w;
            if (i == 26)
               @(posedge clk_sys) wr_en <= 1'b0;
         end
      join_any
      // First decode lands on the fourth edge after release, so it shows
      // at the fifth falling edge counted from the release.
      for (n = 0; n < 20 && decode_valid_reg !== 1'b1; n++)
         @(negedge clk_sys);
      check(21'(n), 21'h000005);
      if (decode_valid_reg !== 1'b1)
         end_sim();
      // One word per four-edge cycle, changed just after a decode edge.
      for (int i = 0; i < 27; i++)
      begin
         r = rows[i];
         if (i > 0)
         begin
            @(posedge clk_sys);
            rd_addr <= i[4:0];
            bank_select_reg <= r.bank;
            skip_taken <= r.skip;
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
         end
         check(21'(op_code_out_reg), 21'(r.op));
         check(21'(flag_mask_reg), 21'(r.mask));
         if (r.cyc != 2'h0)
            check(21'(cycles_reg), 21'(r.cyc));
         if (r.sel != 4'h8)
            check(pick(r.sel), 21'(r.val));
      end
      // Table pointer: load, wrap at 21 bits, load beats increment.
      @(posedge clk_sys);
      table_pointer_value <= 21'h1ffffe;
      table_pointer_load <= 1'b1;
      @(posedge clk_sys);
      table_pointer_load <= 1'b0;
      table_pointer_inc <= 1'b1;
      @(negedge clk_sys);
      check(table_pointer_reg, 21'h1ffffe);
      repeat (2) @(posedge clk_sys);
      table_pointer_value <= 21'h000010;
      table_pointer_load <= 1'b1;
      @(negedge clk_sys);
      check(table_pointer_reg, 21'h000000);
      @(posedge clk_sys);
      table_pointer_load <= 1'b0;
      table_pointer_inc <= 1'b0;
      @(negedge clk_sys);
      check(table_pointer_reg, 21'h000010);
      // A second reset in mid-run clears the decode and the pointer.
      @(posedge clk_sys);
      resetn <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check(21'(decode_valid_reg), 21'h000000);
      check(21'(op_code_out_reg), 21'h000000);
      check(table_pointer_reg, 21'h000000);
      // The phase restarts on release, so the first decode shows at the
      // fifth falling edge again; the fetched word decodes as unknown.
      @(posedge clk_sys);
      resetn <= 1'b1;
      for (n = 0; n < 20 && decode_valid_reg !== 1'b1; n++)
         @(negedge clk_sys);
      check(21'(n), 21'h000005);
      check(21'(op_code_out_reg), 21'h000013);
      end_sim();
   end
endmodule
